// ---- tdt_pkg.sv ----
// Constants, register map and types for the triggered datagram transmit controller
package tdt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned SAMPLE_RATE_HZ = 2000;
    localparam int unsigned SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE_HZ;
    localparam int unsigned SETTLE_US = 1000;
    localparam int unsigned SETTLE_CYCLES = (SETTLE_US * (CLK_HZ / 1_000_000));
    localparam int unsigned PREP_US = 50;
    localparam int unsigned PREP_CYCLES = (PREP_US * (CLK_HZ / 1_000_000));
    localparam int unsigned GAP_US = 20;
    localparam int unsigned GAP_CYCLES = (GAP_US * (CLK_HZ / 1_000_000));
    localparam logic [15:0] DGLEN_RESET = 16'h1000;
    localparam logic [1:0] INIT_LAST = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_REQ = 8'h04;
    localparam logic [7:0] OFS_DRV = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_DGLEN = 8'h10;

    // Field positions
    localparam int unsigned CTRL_TRIG_BIT = 0;
    localparam int unsigned CTRL_MM_BIT = 1;
    localparam int unsigned CTRL_SLOT_LSB = 4;
    localparam int unsigned DRV_RELEASE_BIT = 0;
    localparam int unsigned STAT_SAMP_LSB = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Datagram kinds presented to the serialiser; REQ_RESET is a command only
    typedef enum logic [2:0] {
        DG_SENSOR = 3'h0,
        DG_PART = 3'h1,
        DG_SERIAL = 3'h2,
        DG_CONFIG = 3'h3,
        DG_BIAS = 3'h4,
        DG_EXTERR = 3'h5,
        REQ_RESET = 3'h7
    } tdt_kind_t;

    typedef enum logic [2:0] {
        ST_SETTLE,
        ST_INIT,
        ST_IDLE,
        ST_DELAY,
        ST_TX
    } tdt_fsm_t;

endpackage : tdt_pkg

// ---- tdt_top.sv ----
// Transmit control: reset/trigger pins, init sequence, multi-module slot timing, AHB-Lite registers
//
// What this block does
// R01: Reset pin active low, idle high inactive
// R02: Reset pin forces init mode, no power cycle
// R03: Sampling keeps running at full rate always
// R04: Each trigger falling edge sends one datagram
// R05: Trigger pin rests high, no spurious edge
// R06: Pending special datagram replaces sensor at trigger
// R07: Only newest special request is kept
// R08: Init sends four special datagrams without trigger
// R09: Multi-module only with triggered output selected
// R10: Multi-module releases driver between own transmissions
// R11: Multi-module delays start by slot number
// R12: Driver release stays until explicitly reconfigured
// R13: Units on shared line send in sequence
// R14: Delay is prep plus slot times (datagram+gap)
// R15: Host waits for all units before next trigger
// R16: Init settles, resyncs, then four special datagrams
// R17: Slots distinct, settings identical across units
// R18: Pins synchronised, trigger edge from synced samples
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/100ps

module tdt_top #(
    parameter int unsigned SAMPLE_CYC = tdt_pkg::SAMPLE_CYCLES,
    parameter int unsigned SETTLE_CYC = tdt_pkg::SETTLE_CYCLES
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic RESET_LOW_PIN_N_I,
    input wire logic TRIGGER_IN_PIN_I,
    input wire logic TX_DONE_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    output logic TX_START_O,
    output tdt_pkg::tdt_kind_t TX_KIND_O,
    output logic [15:0] TX_SAMPLE_O,
    output logic TX_DRIVER_EN_O,
    output logic INIT_O
);
    import tdt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Whole module state
    typedef struct packed {
        logic rpin_s1;
        logic rpin_s2;
        logic trig_s1;
        logic trig_s2;
        logic trig_s3;
        tdt_fsm_t st;
        logic [31:0] cnt;
        logic [1:0] idx;
        logic initing;
        logic [15:0] div;
        logic [15:0] samp;
        logic tick;
        logic trig;
        logic mm;
        logic release_drv;
        logic [3:0] slot;
        logic [15:0] dglen;
        logic pend;
        tdt_kind_t pend_kind;
        logic wr;
        logic [7:0] waddr;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        logic tx_start;
        tdt_kind_t tx_kind;
        logic [15:0] tx_samp;
        logic drv;
    } tdt_state_t;

    tdt_state_t q;
    tdt_state_t d;
    logic fall;
    logic addr_ph;
    logic [31:0] mm_dly;
    tdt_kind_t wkind;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        d = q;
        d.tx_start = 1'b0;
        d.tick = 1'b0;
        // Pins pulled high outside; low on the reset pin means reset
        d.rpin_s1 = RESET_LOW_PIN_N_I; // R01
        d.rpin_s2 = q.rpin_s1; // R18
        d.trig_s1 = TRIGGER_IN_PIN_I; // R05
        d.trig_s2 = q.trig_s1; // R18
        d.trig_s3 = q.trig_s2;
        fall = q.trig_s3 && !q.trig_s2; // R18
        // Start offset for this unit's slot on the shared line
        mm_dly = 32'(PREP_CYCLES) + 32'(q.slot) * (32'(q.dglen) + 32'(GAP_CYCLES)); // R14
        wkind = tdt_kind_t'(HWDATA_I[2:0]);

        // Free-running sample divider, never stopped by trigger mode
        if (q.div == 16'(SAMPLE_CYC - 1)) begin // R03
            d.div = 16'h0000;
            d.tick = 1'b1;
            d.samp = q.samp + 16'h0001;
        end else begin
            d.div = q.div + 16'h0001;
        end

        unique case (q.st)
            ST_SETTLE: begin
                // References settle, then channels resync from zero
                if (q.cnt >= 32'(SETTLE_CYC - 1)) begin // R16
                    d.st = ST_INIT;
                    d.div = 16'h0000;
                    d.samp = 16'h0000;
                    d.idx = 2'h0;
                end else begin
                    d.cnt = q.cnt + 32'h1;
                end
            end
            ST_INIT: begin
                // Start-up datagrams go out with no trigger needed
                d.st = ST_TX; // R08
                d.initing = 1'b1;
                d.tx_start = 1'b1;
                d.tx_kind = tdt_kind_t'(3'(q.idx) + 3'h1); // R16
                d.tx_samp = q.samp;
            end
            ST_IDLE: begin
                if ((q.trig && fall) || (!q.trig && q.tick)) begin // R04
                    d.tx_kind = q.pend ? q.pend_kind : DG_SENSOR; // R06
                    d.tx_samp = q.samp;
                    d.pend = 1'b0;
                    if (q.mm) begin
                        d.st = ST_DELAY; // R11
                        d.cnt = mm_dly; // R13
                    end else begin
                        d.st = ST_TX;
                        d.tx_start = 1'b1;
                    end
                end
            end
            ST_DELAY: begin
                if (q.cnt == 32'h0) begin // R11
                    d.st = ST_TX;
                    d.tx_start = 1'b1;
                end else begin
                    d.cnt = q.cnt - 32'h1;
                end
            end
            ST_TX: begin
                // Further triggers are ignored while the line is ours
                if (TX_DONE_I) begin
                    if (q.initing && q.idx != INIT_LAST) begin
                        d.idx = q.idx + 2'h1;
                        d.st = ST_INIT;
                    end else begin
                        d.initing = 1'b0;
                        d.st = ST_IDLE;
                    end
                end
            end
            default: d.st = ST_SETTLE;
        endcase

        ////////////////////////////////////////////////////////////////////////
        // AHB-Lite slave: zero wait states, read data prepared in address phase
        addr_ph = HSEL_I && HTRANS_I[1] && HREADY_I;
        d.ready = 1'b1;
        d.resp = 1'b0;
        d.wr = addr_ph && HWRITE_I;
        d.waddr = HADDR_I[7:0];
        d.rdata = 32'h0000_0000;
        if (addr_ph && !HWRITE_I) begin
            unique case (HADDR_I[7:0])
                OFS_CTRL: begin
                    d.rdata[CTRL_TRIG_BIT] = q.trig;
                    d.rdata[CTRL_MM_BIT] = q.mm;
                    d.rdata[CTRL_SLOT_LSB +: 4] = q.slot;
                end
                OFS_REQ: d.rdata[2:0] = q.pend_kind;
                OFS_DRV: d.rdata[DRV_RELEASE_BIT] = q.release_drv;
                OFS_STAT: begin
                    d.rdata[0] = q.initing || q.st == ST_SETTLE || q.st == ST_INIT;
                    d.rdata[1] = q.st == ST_TX || q.st == ST_DELAY;
                    d.rdata[2] = q.pend;
                    d.rdata[3] = q.release_drv;
                    d.rdata[6:4] = q.pend_kind;
                    d.rdata[STAT_SAMP_LSB +: 16] = q.samp;
                end
                OFS_DGLEN: d.rdata[15:0] = q.dglen;
                default: d.rdata = 32'h0000_0000;
            endcase
        end
        // Write data phase; a new request wins over the serve above
        if (q.wr) begin
            unique case (q.waddr)
                OFS_CTRL: begin
                    d.trig = HWDATA_I[CTRL_TRIG_BIT];
                    d.mm = HWDATA_I[CTRL_TRIG_BIT] && HWDATA_I[CTRL_MM_BIT]; // R09
                    d.slot = HWDATA_I[CTRL_SLOT_LSB +: 4]; // R17
                    if (HWDATA_I[CTRL_TRIG_BIT] && HWDATA_I[CTRL_MM_BIT]) begin
                        d.release_drv = 1'b1; // R10
                    end
                end
                OFS_REQ: begin
                    if (wkind == REQ_RESET) begin
                        d.st = ST_SETTLE;
                        d.cnt = 32'h0;
                        d.initing = 1'b0;
                        d.pend = 1'b0;
                    end else if (wkind != DG_SENSOR && wkind != tdt_kind_t'(3'h6)) begin
                        d.pend = 1'b1; // R07
                        d.pend_kind = wkind; // R07
                    end
                end
                // Only an explicit write here clears the release setting
                OFS_DRV: d.release_drv = HWDATA_I[DRV_RELEASE_BIT]; // R12
                OFS_DGLEN: d.dglen = HWDATA_I[15:0];
                default: d.dglen = q.dglen;
            endcase
        end

        // Reset pin held low keeps the unit in init
        if (!q.rpin_s2) begin // R02
            d.st = ST_SETTLE;
            d.cnt = 32'h0;
            d.initing = 1'b0;
            d.pend = 1'b0;
        end
        d.drv = !d.release_drv || d.st == ST_TX; // R10
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            q <= '{rpin_s1: 1'b1, rpin_s2: 1'b1, trig_s1: 1'b1, trig_s2: 1'b1, trig_s3: 1'b1,
                   st: ST_SETTLE, dglen: DGLEN_RESET, pend_kind: DG_SENSOR, tx_kind: DG_SENSOR,
                   ready: 1'b1, drv: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign HRDATA_O = q.rdata;
    assign HREADYOUT_O = q.ready;
    assign HRESP_O = q.resp;
    assign TX_START_O = q.tx_start;
    assign TX_KIND_O = q.tx_kind;
    assign TX_SAMPLE_O = q.tx_samp;
    assign TX_DRIVER_EN_O = q.drv;
    assign INIT_O = q.initing;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    pin_reset_init_a: assert property (!q.rpin_s2 |=> q.st == ST_SETTLE && !INIT_O) // R02
        else $error("reset pin did not force init");
    sample_tick_a: assert property (q.tick && $past(q.st) != ST_SETTLE |-> q.samp == $past(q.samp) + 16'h0001) // R03
        else $error("sample counter did not advance on tick");
    trig_start_a: assert property (q.st == ST_IDLE && q.trig && !q.mm && fall && q.rpin_s2 && !q.wr // R04
        |=> TX_START_O ##1 !TX_START_O)
        else $error("trigger edge did not start exactly one datagram");
    pend_served_a: assert property (q.st == ST_IDLE && q.trig && fall && q.pend && q.rpin_s2 // R06
        |=> TX_KIND_O == $past(q.pend_kind))
        else $error("pending special datagram not sent at trigger");
    last_req_a: assert property (q.wr && q.waddr == OFS_REQ && HWDATA_I[2:0] inside {[3'h1:3'h5]} && q.rpin_s2 // R07
        |=> q.pend && q.pend_kind == $past(wkind))
        else $error("newest special request not kept");
    init_no_trig_a: assert property (q.st == ST_INIT && q.rpin_s2 && !q.wr |=> TX_START_O && TX_KIND_O != DG_SENSOR) // R08
        else $error("init datagram not started");
    mm_needs_trig_a: assert property (q.mm |-> q.trig) // R09
        else $error("multi-module on without triggered output");
    drv_release_a: assert property (q.release_drv && q.st != ST_TX |-> !TX_DRIVER_EN_O) // R10
        else $error("driver held while released between transmissions");
    slot_delay_a: assert property (q.st == ST_IDLE && q.trig && q.mm && fall && q.rpin_s2 && !q.wr // R11
        |=> q.st == ST_DELAY && q.cnt == $past(mm_dly))
        else $error("slot delay not loaded");
    release_sticky_a: assert property ($fell(q.mm) |-> q.release_drv) // R12
        else $error("release setting dropped with multi-module");

    init_done_c: cover property (q.initing ##1 !q.initing && q.st == ST_IDLE);
    trig_sensor_c: cover property (TX_START_O && TX_KIND_O == DG_SENSOR && q.trig);
    trig_special_c: cover property (TX_START_O && TX_KIND_O == DG_CONFIG && !q.initing);
    mm_delayed_c: cover property (q.st == ST_DELAY && q.slot != 4'h0 ##1 q.st == ST_DELAY);

endmodule // tdt_top

// ---- tdt_ser_model.sv ----
// Serialiser stand-in that answers each datagram start with a done pulse
`timescale 1ns/100ps

module tdt_ser_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [7:0] len_i,
    output logic done_o
);
    logic [7:0] cnt_q;

    // Counts down a datagram; one datagram at a time, so frames never overlap
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt_q == 8'h01);
            if (start_i) begin
                cnt_q <= len_i;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule // tdt_ser_model

// ---- tdt_top_tb.sv ----
// Self-checking bench for the triggered datagram transmit controller
`timescale 1ns/100ps

module tdt_top_tb;
    import tdt_pkg::*;
    localparam int unsigned SCYC = 20;
    localparam int unsigned TCYC = 16;
    localparam int unsigned TLIM = 20000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pin_rst_n = 1'b1;
    logic trig = 1'b1;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] ser_len = 8'h03;
    logic [31:0] hrdata, q, q2;
    logic [15:0] dq;
    logic hready, hresp, start, drv, init, done;
    tdt_kind_t kind;
    logic [15:0] sample;
    int num_errors = 0;
    int compares = 0;
    int cyc = 0;
    int starts = 0;
    int n;

    tdt_top #(.SAMPLE_CYC(SCYC), .SETTLE_CYC(TCYC)) u_dut (
        .CLK_I(clk), .RST_N_I(rst_n), .RESET_LOW_PIN_N_I(pin_rst_n), .TRIGGER_IN_PIN_I(trig),
        .TX_DONE_I(done), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
        .HRESP_O(hresp), .TX_START_O(start), .TX_KIND_O(kind), .TX_SAMPLE_O(sample),
        .TX_DRIVER_EN_O(drv), .INIT_O(init));
    tdt_ser_model u_ser (.clk_i(clk), .rst_n_i(rst_n), .start_i(start), .len_i(ser_len), .done_o(done));

    ////////////////////////////////////////
    // Clock, timeout and start counter
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        starts += (start === 1'b1);
        if (cyc == TLIM) begin
            num_errors++;
            complete_run();
        end
    end

    ////////////////////////////////////////
    task automatic complete_run();
        if (num_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One single AHB transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(what, e, r);
        chk("hresp okay", 32'h0, {31'h0, hresp});
    endtask

    // Sampled at falling edges, where registered outputs have settled
    task automatic wait_start(input string what, input tdt_kind_t k, output int w);
        w = 0;
        do begin
            @(negedge clk);
            w++;
        end while (start !== 1'b1 && w < 3000);
        // A wait that runs out must count, not slip through on a matching kind
        chk("start seen", 32'h1, {31'h0, start});
        chk(what, {29'h0, k}, {29'h0, kind});
        @(posedge clk);
    endtask

    task automatic fire(input string what, input tdt_kind_t k, input int lo, input int hi);
        int w;
        trig <= 1'b0;
        wait_start(what, k, w);
        chk("latency ok", 32'h1, 32'(w >= lo && w <= hi));
        trig <= 1'b1;
        repeat (ser_len + 6) @(posedge clk);
    endtask

    task automatic init_seq(input string what);
        int w;
        for (int k = 1; k <= 4; k++) begin
            wait_start(what, tdt_kind_t'(k), w);
            // Channels resync from zero, so the first start-up datagram carries sample 0
            if (k == 1) chk("init sample", 32'h0, {16'h0, sample});
            chk("init flag", 32'h1, {31'h0, init});
        end
        repeat (ser_len + 6) @(posedge clk);
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        chk("drv in reset", 32'h1, {31'h0, drv});
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk("DGLEN reset", OFS_DGLEN, 32'h1000);
        rd_chk("unmapped", 8'h14, 32'h0);
        init_seq("power-up");
        // Free running: sample counter steps once per sample period
        wait_start("free run", DG_SENSOR, n);
        bus(1'b0, OFS_STAT, 32'h0, q);
        repeat (3 * SCYC - 2) @(posedge clk);
        bus(1'b0, OFS_STAT, 32'h0, q2);
        dq = q2[31:16] - q[31:16];
        chk("sample step", 32'h3, {16'h0, dq});
        wr(OFS_DGLEN, 32'h8);
        wr(OFS_CTRL, 32'h1);
        repeat (SCYC) @(posedge clk);
        n = starts;
        repeat (2 * SCYC) @(posedge clk);
        chk("idle pin", n, starts);
        fire("trig sensor", DG_SENSOR, 4, 4);
        ser_len <= 8'h0C;
        for (int k = 1; k <= 5; k++) begin
            wr(OFS_REQ, k);
            fire("special", tdt_kind_t'(k), 4, 4);
        end
        wr(OFS_REQ, 32'h2);
        wr(OFS_REQ, 32'h6);
        wr(OFS_REQ, 32'h4);
        rd_chk("REQ newest", OFS_REQ, 32'h4);
        fire("newest", DG_BIAS, 4, 4);
        fire("cleared", DG_SENSOR, 4, 4);
        // Multi-module slots; delay grows with slot number
        for (int s = 0; s <= 3; s += 3) begin
            wr(OFS_CTRL, 32'h3 | (s << 4));
            rd_chk("DRV set", OFS_DRV, 32'h1);
            chk("drv idle", 32'h0, {31'h0, drv});
            n = 5 + PREP_CYCLES + s * (8 + GAP_CYCLES);
            fire("mm", DG_SENSOR, n, n + 3);
        end
        wr(OFS_CTRL, 32'h1);
        rd_chk("DRV kept", OFS_DRV, 32'h1);
        chk("drv kept", 32'h0, {31'h0, drv});
        wr(OFS_DRV, 32'h0);
        repeat (2) @(posedge clk);
        chk("drv back", 32'h1, {31'h0, drv});
        wr(OFS_CTRL, 32'h2);
        rd_chk("mm needs trig", OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h1);
        repeat (SCYC) @(posedge clk);
        pin_rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        pin_rst_n <= 1'b1;
        init_seq("pin reset");
        wr(OFS_CTRL, 32'h1);
        repeat (SCYC) @(posedge clk);
        wr(OFS_REQ, 32'h7);
        init_seq("reset cmd");
        complete_run();
    end
endmodule // tdt_top_tb
